// *** logic/bridge_fault_pkg.sv ***
// Purpose : constants for the bridge fault status and timing config block
// Assumes : 20 MHz core clock, register access decoded from the serial link
// Notes   : offsets, field positions, the status and config reset words and the step sizes live here
//
// Contract
// RULE_01: over-current in a switch sets its own flag and turns that gate off.
// RULE_02: any per-switch over-current flag also raises the summary flag.
// RULE_03: a gate tripped by over-current stays off until host clears flag.
// RULE_04: supply under-voltage turns all gates off and latches its flag.
// RULE_05: supply over-voltage turns all gates off and latches its flag.
// RULE_06: under-voltage recovery enabled: gates return once supply recovers.
// RULE_07: over-voltage recovery enabled: gates return once supply recovers.
// RULE_08: rise no-crossing limit is 250 ns times field plus one, reset zero.
// RULE_09: fall no-crossing limit uses the same coding, reset zero.
// RULE_10: 3-bit over-current threshold, 0.25 V at zero in 0.25 V steps.
// RULE_11: half-bridge topology drives from control bits only, pwm ignored.
// RULE_12: with recovery disabled host clears supply flag before gates return.
// RULE_13: flags read one while latched, read clears, live fault sets again.
// RULE_14: flags and config reset to zero, unused bits always read zero.
package bridge_fault_pkg;

   // -------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------
   localparam logic [5:0]  FAULT_STATUS_ADDR        = 6'h10;
   localparam logic [5:0]  DRIVE_TIMING_CONFIG_ADDR = 6'h3f;
   localparam logic [15:0] FAULT_STATUS_RESET       = 16'h0000;
   localparam logic [15:0] DRIVE_TIMING_CONFIG_RESET = 16'h0000;
   localparam logic [15:0] DRIVE_TIMING_CONFIG_MASK = 16'hfff8;

   // -------------------------------------------------------------------
   // fault_status bit positions
   // -------------------------------------------------------------------
   localparam int OC_HIGH_SIDE_A_BIT = 9;
   localparam int OC_LOW_SIDE_A_BIT  = 8;
   localparam int OC_HIGH_SIDE_B_BIT = 7;
   localparam int OC_LOW_SIDE_B_BIT  = 6;
   localparam int UNDERVOLTAGE_BIT   = 3;
   localparam int OVERVOLTAGE_BIT    = 2;

   // -------------------------------------------------------------------
   // drive_timing_config field positions
   // -------------------------------------------------------------------
   localparam int RISE_NC_LSB   = 12;
   localparam int FALL_NC_LSB   = 8;
   localparam int OC_THRESH_LSB = 5;
   localparam int TOPOLOGY_BIT  = 4;
   localparam int SLEW_BIT      = 3;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS   = 50;
   localparam int NO_CROSS_STEP_NS  = 250;
   localparam int NO_CROSS_STEP_CYC = NO_CROSS_STEP_NS / CLOCK_PERIOD_NS;
   localparam int OC_THRESH_STEP_MV = 250;

endpackage

// *** logic/pin_sync2.sv ***
// Purpose : two flop synchroniser bank for asynchronous pin levels
// Assumes : inputs are slow levels, no pulse shorter than two clocks
// Notes   : first stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         i_clock,
   input  wire logic         i_arst_n,
   input  wire logic         i_clk_en,
   // levels
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   logic [W-1:0] meta_r;

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_r <= '0;
         o_sync <= '0;
      end else if (i_clk_en) begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end

endmodule

// *** logic/bridge_fault_status_config_regs.sv ***
// Purpose : fault status flags, gate masking and drive timing config
// Assumes : register strobes come from the link decoder on this clock
// Notes   : analog fault comparators and pwm arrive as raw pin levels
`timescale 1ns/1ps
module bridge_fault_status_config_regs (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_arst_n,
   input  wire logic        i_clk_en,
   // register access
   input  wire logic [5:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic [15:0] i_reg_wdata,
   input  wire logic        i_reg_rd,
   output logic      [15:0] o_reg_rdata,
   // control bits held by the control register
   input  wire logic        i_ctrl_high_side_a,
   input  wire logic        i_ctrl_low_side_a,
   input  wire logic        i_ctrl_high_side_b,
   input  wire logic        i_ctrl_low_side_b,
   input  wire logic        i_freewheel_side_select,
   input  wire logic        i_freewheel_active_select,
   input  wire logic        i_undervoltage_recovery_disable,
   input  wire logic        i_overvoltage_recovery_disable,
   // raw pins and comparator levels
   input  wire logic        i_pwm,
   input  wire logic        i_overcurrent_high_side_a,
   input  wire logic        i_overcurrent_low_side_a,
   input  wire logic        i_overcurrent_high_side_b,
   input  wire logic        i_overcurrent_low_side_b,
   input  wire logic        i_supply_undervoltage,
   input  wire logic        i_supply_overvoltage,
   // gate enables
   output logic             o_gate_high_side_a,
   output logic             o_gate_low_side_a,
   output logic             o_gate_high_side_b,
   output logic             o_gate_low_side_b,
   // status and configuration
   output logic             o_summary_fault_flag,
   output logic      [3:0]  o_rise_no_crossing_limit,
   output logic      [3:0]  o_fall_no_crossing_limit,
   output logic      [6:0]  o_rise_no_crossing_cycles,
   output logic      [6:0]  o_fall_no_crossing_cycles,
   output logic      [2:0]  o_overcurrent_threshold,
   output logic             o_bridge_topology_select,
   output logic             o_gate_slew_select
);

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   function automatic logic [6:0] no_cross_cycles(input logic [3:0] code);
      no_cross_cycles = 7'((int'(code) + 1) *
                           bridge_fault_pkg::NO_CROSS_STEP_CYC);
   endfunction

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   logic [6:0] pins_sync;
   logic       pwm_s;
   logic [3:0] oc_s;
   logic       uv_s;
   logic       ov_s;

   pin_sync2 #(.W(7)) u_sync (
      .i_clock  (i_clock),
      .i_arst_n (i_arst_n),
      .i_clk_en (i_clk_en),
      .i_async  ({i_pwm, i_overcurrent_high_side_a,
                  i_overcurrent_low_side_a, i_overcurrent_high_side_b,
                  i_overcurrent_low_side_b, i_supply_undervoltage,
                  i_supply_overvoltage}),
      .o_sync   (pins_sync)
   );

   assign pwm_s = pins_sync[6];
   assign oc_s  = pins_sync[5:2];
   assign uv_s  = pins_sync[1];
   assign ov_s  = pins_sync[0];

   // -------------------------------------------------------------------
   // fault flags
   // -------------------------------------------------------------------
   logic [3:0]  oc_flag_r;
   logic [3:0]  oc_flag_nxt;
   logic        uv_flag_r;
   logic        uv_flag_nxt;
   logic        ov_flag_r;
   logic        ov_flag_nxt;
   logic        status_clr;
   logic [15:0] status_word;
   logic [15:0] config_r;

   assign status_clr = i_reg_rd &&
                       (i_reg_addr == bridge_fault_pkg::FAULT_STATUS_ADDR);

   // a live fault wins over the read clear so no event is lost
   assign oc_flag_nxt = oc_s | (oc_flag_r & {4{!status_clr}}); // RULE_01
   assign uv_flag_nxt = uv_s | (uv_flag_r & !status_clr); // RULE_04 RULE_13
   assign ov_flag_nxt = ov_s | (ov_flag_r & !status_clr); // RULE_05 RULE_13

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         oc_flag_r <= 4'h0; // RULE_14
         uv_flag_r <= 1'b0;
         ov_flag_r <= 1'b0;
         o_summary_fault_flag <= 1'b0;
      end else if (i_clk_en) begin
         oc_flag_r <= oc_flag_nxt;
         uv_flag_r <= uv_flag_nxt;
         ov_flag_r <= ov_flag_nxt;
         o_summary_fault_flag <= (|oc_flag_nxt) | uv_flag_nxt |
                                 ov_flag_nxt; // RULE_02
      end
   end

   // -------------------------------------------------------------------
   // gate command and fault masking
   // -------------------------------------------------------------------
   logic [3:0] cmd;
   logic [3:0] gate_nxt;
   logic       supply_block;
   logic       hs_a_req;
   logic       ls_a_req;
   logic       hs_b_req;
   logic       ls_b_req;

   // both switches of a leg requested means neither is driven
   assign hs_a_req = i_ctrl_high_side_a & !i_ctrl_low_side_a;
   assign ls_a_req = i_ctrl_low_side_a & !i_ctrl_high_side_a;
   assign hs_b_req = i_ctrl_high_side_b & !i_ctrl_low_side_b;
   assign ls_b_req = i_ctrl_low_side_b & !i_ctrl_high_side_b;

   always_comb begin
      cmd = {hs_a_req, ls_a_req, hs_b_req, ls_b_req};
      if (!o_bridge_topology_select && !pwm_s) begin // RULE_11
         if (!i_freewheel_side_select) begin
            cmd = {1'b0, ls_a_req | (i_freewheel_active_select & hs_a_req),
                   1'b0, ls_b_req | (i_freewheel_active_select & hs_b_req)};
         end else begin
            cmd = {hs_a_req | (i_freewheel_active_select & ls_a_req), 1'b0,
                   hs_b_req | (i_freewheel_active_select & ls_b_req), 1'b0};
         end
      end
   end

   // live supply faults always block; latched ones only without recovery
   assign supply_block = uv_s | ov_s // RULE_04 RULE_05 RULE_06 RULE_07
      | (i_undervoltage_recovery_disable & uv_flag_nxt) // RULE_12
      | (i_overvoltage_recovery_disable & ov_flag_nxt); // RULE_12

   assign gate_nxt = cmd & ~oc_flag_nxt & {4{!supply_block}}; // RULE_03

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_gate_high_side_a <= 1'b0;
         o_gate_low_side_a  <= 1'b0;
         o_gate_high_side_b <= 1'b0;
         o_gate_low_side_b  <= 1'b0;
      end else if (i_clk_en) begin
         o_gate_high_side_a <= gate_nxt[3]; // RULE_01
         o_gate_low_side_a  <= gate_nxt[2];
         o_gate_high_side_b <= gate_nxt[1];
         o_gate_low_side_b  <= gate_nxt[0];
      end
   end

   // -------------------------------------------------------------------
   // configuration register
   // -------------------------------------------------------------------
   logic [15:0] config_nxt;

   assign config_nxt = i_reg_wdata &
                       bridge_fault_pkg::DRIVE_TIMING_CONFIG_MASK;

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         config_r <= bridge_fault_pkg::DRIVE_TIMING_CONFIG_RESET; // RULE_14
      end else if (i_clk_en && i_reg_wr &&
                   (i_reg_addr ==
                    bridge_fault_pkg::DRIVE_TIMING_CONFIG_ADDR)) begin
         config_r <= config_nxt;
      end
   end

   // outputs lag the register by one clock so they come from flops too
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rise_no_crossing_limit  <= 4'h0;
         o_fall_no_crossing_limit  <= 4'h0;
         o_rise_no_crossing_cycles <= 7'(bridge_fault_pkg::NO_CROSS_STEP_CYC);
         o_fall_no_crossing_cycles <= 7'(bridge_fault_pkg::NO_CROSS_STEP_CYC);
         o_overcurrent_threshold   <= 3'h0;
         o_bridge_topology_select  <= 1'b0;
         o_gate_slew_select        <= 1'b0;
      end else if (i_clk_en) begin
         o_rise_no_crossing_limit  <=
            config_r[bridge_fault_pkg::RISE_NC_LSB +: 4];
         o_fall_no_crossing_limit  <=
            config_r[bridge_fault_pkg::FALL_NC_LSB +: 4];
         o_rise_no_crossing_cycles <= no_cross_cycles( // RULE_08
            config_r[bridge_fault_pkg::RISE_NC_LSB +: 4]);
         o_fall_no_crossing_cycles <= no_cross_cycles( // RULE_09
            config_r[bridge_fault_pkg::FALL_NC_LSB +: 4]);
         o_overcurrent_threshold   <= // RULE_10
            config_r[bridge_fault_pkg::OC_THRESH_LSB +: 3];
         o_bridge_topology_select  <=
            config_r[bridge_fault_pkg::TOPOLOGY_BIT];
         o_gate_slew_select        <= config_r[bridge_fault_pkg::SLEW_BIT];
      end
   end

   // -------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------
   always_comb begin
      status_word = bridge_fault_pkg::FAULT_STATUS_RESET;
      status_word[bridge_fault_pkg::OC_HIGH_SIDE_A_BIT] = oc_flag_r[3];
      status_word[bridge_fault_pkg::OC_LOW_SIDE_A_BIT]  = oc_flag_r[2];
      status_word[bridge_fault_pkg::OC_HIGH_SIDE_B_BIT] = oc_flag_r[1];
      status_word[bridge_fault_pkg::OC_LOW_SIDE_B_BIT]  = oc_flag_r[0];
      status_word[bridge_fault_pkg::UNDERVOLTAGE_BIT]   = uv_flag_r;
      status_word[bridge_fault_pkg::OVERVOLTAGE_BIT]    = ov_flag_r;
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_clk_en && i_reg_rd) begin
         case (i_reg_addr)
            bridge_fault_pkg::FAULT_STATUS_ADDR:
               o_reg_rdata <= status_word; // RULE_13
            bridge_fault_pkg::DRIVE_TIMING_CONFIG_ADDR:
               o_reg_rdata <= config_r;
            default:
               o_reg_rdata <= 16'h0000; // RULE_14
         endcase
      end
   end

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   a_oc_sets_flag: assert property ( // RULE_01
      @(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
      oc_s[3] |=> oc_flag_r[3] && !o_gate_high_side_a)
      else $error("over-current did not latch flag or gate stayed on");
   a_oc_summary: assert property ( // RULE_02
      @(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
      (|oc_flag_r) |-> o_summary_fault_flag)
      else $error("summary flag missing with over-current flag set");
   a_oc_gate_held: assert property ( // RULE_03
      @(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
      oc_flag_r[0] |-> !o_gate_low_side_b)
      else $error("gate on while its over-current flag is latched");
   a_uv_all_off: assert property ( // RULE_04
      @(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
      uv_s |=> uv_flag_r && !o_gate_high_side_a && !o_gate_low_side_a
               && !o_gate_high_side_b && !o_gate_low_side_b)
      else $error("under-voltage did not stop all gates");
   a_ov_all_off: assert property ( // RULE_05
      @(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
      ov_s |=> ov_flag_r && !o_gate_high_side_a && !o_gate_low_side_a
               && !o_gate_high_side_b && !o_gate_low_side_b)
      else $error("over-voltage did not stop all gates");
   a_uv_recovers: assert property ( // RULE_06
      @(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
      (!uv_s && !ov_s && !i_undervoltage_recovery_disable
       && !i_overvoltage_recovery_disable && oc_flag_nxt == 4'h0
       && o_bridge_topology_select && hs_a_req)
      |=> o_gate_high_side_a)
      else $error("gate not restored after supply recovered");
   a_uv_no_auto: assert property ( // RULE_12
      @(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
      (i_undervoltage_recovery_disable && uv_flag_r && !status_clr)
      |=> !o_gate_high_side_a)
      else $error("gate restored while latched supply fault pending");
   a_rise_cycles: assert property ( // RULE_08
      @(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
      o_rise_no_crossing_cycles ==
         7'((o_rise_no_crossing_limit + 7'd1) * 7'd5))
      else $error("rise no-crossing cycle count wrong");
   a_fall_cycles: assert property ( // RULE_09
      @(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
      $changed(config_r[11:8]) |=> o_fall_no_crossing_cycles ==
         7'(($past(config_r[11:8]) + 7'd1) * 7'd5))
      else $error("fall no-crossing cycle count wrong");
   a_rc_clears: assert property ( // RULE_13
      @(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
      (status_clr && !uv_s && uv_flag_r) |=> !uv_flag_r)
      else $error("read did not clear under-voltage flag");
   a_unused_zero: assert property ( // RULE_14
      @(posedge i_clock) disable iff (!i_arst_n || !i_clk_en)
      status_clr |=> (o_reg_rdata & 16'hfc33) == 16'h0000
         && config_r[2:0] == 3'h0)
      else $error("unused register bit reads one");

endmodule

// *** bench/host_link_model.sv ***
// Purpose : host side of the register access, one access per call
// Assumes : strobes one cycle wide, driven on the falling edge
// Notes   : idle address and data lines show the inverse of the last value, strobes low
`timescale 1ns/1ps
module host_link_model (
   // clock
   input  wire logic        i_clock,
   // register access
   output logic      [5:0]  o_reg_addr,
   output logic             o_reg_wr,
   output logic      [15:0] o_reg_wdata,
   output logic             o_reg_rd,
   input  wire logic [15:0] i_reg_rdata
);
   initial begin
      o_reg_addr  = 6'h00;
      o_reg_wr    = 1'b0;
      o_reg_wdata = 16'h0000;
      o_reg_rd    = 1'b0;
   end

   // read of the status word is also the flag clear the host owes
   task automatic access(input logic [5:0] a, input logic w, input logic r,
                         input logic [15:0] d, output logic [15:0] q);
      @(negedge i_clock);
      o_reg_addr  = a;
      o_reg_wdata = d;
      o_reg_wr    = w;
      o_reg_rd    = r;
      @(negedge i_clock);
      q           = i_reg_rdata;
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_addr  = ~a;
      o_reg_wdata = ~d;
   endtask
endmodule

// *** bench/tb_top.sv ***
// Purpose : self-checking bench for the fault status and config block
// Assumes : host model owns the register strobes, bench owns the pins
// Notes   : pins settle four cycles, two sync stages, the flag register and one spare
`timescale 1ns/1ps
module tb_top;
   logic        i_clock, i_arst_n, reg_wr, reg_rd, summary, topo, slew;
   logic        fw_side, fw_act, uv_dis, ov_dis, pwm, uv_pin, ov_pin;
   logic [5:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd_q, cfg;
   logic [3:0]  ctrl, oc_pin, gate, rise_f, fall_f, m_oc;
   logic [6:0]  rise_c, fall_c;
   logic [2:0]  overcurrent_threshold;
   logic        m_uv, m_ov;
   logic        clk_en;
   int          miscompares, samples_checked, cycles;

   host_link_model host (.i_clock(i_clock), .o_reg_addr(reg_addr),
      .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd),
      .i_reg_rdata(reg_rdata));

   bridge_fault_status_config_regs DUT (.i_clock(i_clock),
      .i_arst_n(i_arst_n), .i_clk_en(clk_en), .i_reg_addr(reg_addr),
      .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd),
      .o_reg_rdata(reg_rdata), .i_ctrl_high_side_a(ctrl[3]),
      .i_ctrl_low_side_a(ctrl[2]), .i_ctrl_high_side_b(ctrl[1]),
      .i_ctrl_low_side_b(ctrl[0]), .i_freewheel_side_select(fw_side),
      .i_freewheel_active_select(fw_act),
      .i_undervoltage_recovery_disable(uv_dis),
      .i_overvoltage_recovery_disable(ov_dis), .i_pwm(pwm),
      .i_overcurrent_high_side_a(oc_pin[3]),
      .i_overcurrent_low_side_a(oc_pin[2]),
      .i_overcurrent_high_side_b(oc_pin[1]),
      .i_overcurrent_low_side_b(oc_pin[0]),
      .i_supply_undervoltage(uv_pin), .i_supply_overvoltage(ov_pin),
      .o_gate_high_side_a(gate[3]), .o_gate_low_side_a(gate[2]),
      .o_gate_high_side_b(gate[1]), .o_gate_low_side_b(gate[0]),
      .o_summary_fault_flag(summary), .o_rise_no_crossing_limit(rise_f),
      .o_fall_no_crossing_limit(fall_f), .o_rise_no_crossing_cycles(rise_c),
      .o_fall_no_crossing_cycles(fall_c), .o_overcurrent_threshold(overcurrent_threshold),
      .o_bridge_topology_select(topo), .o_gate_slew_select(slew));

   initial i_clock = 1'b0;
   always #25 i_clock = ~i_clock;

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         give_verdict();
      end
   end

   // -------------------------------------------------------------
   // model and compares
   // -------------------------------------------------------------
   function automatic logic [15:0] m_status();
      return {6'h00, m_oc, 2'b00, m_uv, m_ov, 2'b00};
   endfunction

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // live supply fault blocks always; latched one only with recovery off
   task automatic chk_drive();
      logic       blk;
      logic [3:0] c;
      blk = uv_pin | ov_pin | (uv_dis & m_uv) | (ov_dis & m_ov);
      // both switches of one leg asked for leaves that leg off
      c = ctrl & ~{ctrl[2], ctrl[3], ctrl[0], ctrl[1]};
      if (!cfg[bridge_fault_pkg::TOPOLOGY_BIT] && !pwm && fw_side) begin
         c = {c[3] | (fw_act & c[2]), 1'b0, c[1] | (fw_act & c[0]), 1'b0};
      end else if (!cfg[bridge_fault_pkg::TOPOLOGY_BIT] && !pwm) begin
         c = {1'b0, c[2] | (fw_act & c[3]), 1'b0, c[0] | (fw_act & c[1])};
      end
      chk_word({11'h000, gate, summary},
               {11'h000, c & ~m_oc & {4{~blk}}, |m_status()});
   endtask

   task automatic chk_cfg(input logic [15:0] c);
      int r;
      int f;
      r = (c[15:12] + 1) * bridge_fault_pkg::NO_CROSS_STEP_CYC;
      f = (c[11:8] + 1) * bridge_fault_pkg::NO_CROSS_STEP_CYC;
      chk_word({rise_f, fall_f, overcurrent_threshold, topo, slew, 3'b000},
               c & bridge_fault_pkg::DRIVE_TIMING_CONFIG_MASK);
      chk_word({2'b00, rise_c, fall_c}, {2'b00, 7'(r), 7'(f)});
   endtask

   task automatic settle();
      repeat (4) @(negedge i_clock);
      m_oc = m_oc | oc_pin;
      m_uv = m_uv | uv_pin;
      m_ov = m_ov | ov_pin;
   endtask

   task automatic read_status();
      host.access(bridge_fault_pkg::FAULT_STATUS_ADDR, 1'b0, 1'b1,
                  16'h0000, rd_q);
      chk_word(rd_q, m_status());
      m_oc = oc_pin;
      m_uv = uv_pin;
      m_ov = ov_pin;
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // stimulus
   // -------------------------------------------------------------
   initial begin
      {i_arst_n, ctrl, oc_pin, fw_side, fw_act, uv_dis, ov_dis} = '0;
      {pwm, uv_pin, ov_pin, m_oc, m_uv, m_ov} = '0;
      cfg = 16'h0000;
      clk_en = 1'b1;
      miscompares = 0;
      samples_checked = 0;
      cycles = 0;
      void'($urandom(32'had8f80b0));
      repeat (20) @(negedge i_clock);
      i_arst_n = 1'b1;
      chk_cfg(16'h0000);
      chk_drive();
      read_status();
      host.access(6'h01, 1'b0, 1'b1, 16'h0000, rd_q);
      chk_word(rd_q, 16'h0000);
      $display("test reset done");
      // status is read-only: a write there must not land anywhere
      host.access(bridge_fault_pkg::FAULT_STATUS_ADDR, 1'b1, 1'b0,
                  16'hffff, rd_q);
      read_status();
      for (int i = 0; i < 10; i++) begin
         cfg = (i == 9) ? 16'hffff : 16'($urandom);
         cfg[7:5] = (i < 8) ? i[2:0] : cfg[7:5];
         host.access(bridge_fault_pkg::DRIVE_TIMING_CONFIG_ADDR, 1'b1,
                     1'b0, cfg, rd_q);
         repeat (2) @(negedge i_clock);
         chk_cfg(cfg);
         host.access(bridge_fault_pkg::DRIVE_TIMING_CONFIG_ADDR, 1'b0,
                     1'b1, 16'h0000, rd_q);
         chk_word(rd_q, cfg & 16'hfff8);
      end
      $display("test config done");
      cfg = 16'h0001 << bridge_fault_pkg::TOPOLOGY_BIT;
      host.access(bridge_fault_pkg::DRIVE_TIMING_CONFIG_ADDR, 1'b1, 1'b0,
                  cfg, rd_q);
      for (int s = 0; s < 4; s++) begin
         ctrl = 4'b1000 >> s;
         {pwm, fw_side, fw_act} = 3'($urandom);
         settle();
         chk_drive();
         oc_pin = ctrl;
         settle();
         chk_drive();
         oc_pin = 4'h0;
         settle();
         chk_drive();
         read_status();
         settle();
         chk_drive();
      end
      $display("test overcurrent done");
      ctrl = 4'b1001;
      for (int k = 0; k < 4; k++) begin
         uv_dis = k[0];
         ov_dis = k[0];
         uv_pin = (k < 2);
         ov_pin = (k >= 2);
         settle();
         chk_drive();
         read_status();
         {uv_pin, ov_pin} = 2'b00;
         settle();
         chk_drive();
         read_status();
         settle();
         chk_drive();
         read_status();
      end
      $display("test supply done");
      // clock enable low must freeze the block against a live fault
      clk_en = 1'b0;
      uv_pin = 1'b1;
      repeat (6) @(negedge i_clock);
      chk_word({11'h000, gate, summary}, {11'h000, ctrl, 1'b0});
      clk_en = 1'b1;
      settle();
      chk_drive();
      read_status();
      uv_pin = 1'b0;
      settle();
      read_status();
      $display("test clock enable done");
      cfg = 16'h0000;
      host.access(bridge_fault_pkg::DRIVE_TIMING_CONFIG_ADDR, 1'b1, 1'b0,
                  cfg, rd_q);
      for (int j = 0; j < 16; j++) begin
         ctrl = 4'($urandom);
         {pwm, fw_side, fw_act} = j[2:0];
         settle();
         chk_drive();
      end
      $display("test full bridge done");
      give_verdict();
   end
endmodule
